// [hw/addr_mode_regs.vh]
`ifndef ADDR_MODE_REGS_VH
`define ADDR_MODE_REGS_VH
// Mode field codes
`define MODE_W 5
`define MODE_REGREL_HI 2'b01
`define MODE_FRAME_MREL 5'h10
`define MODE_STACK_MREL 5'h11
`define MODE_STATIC_MREL 5'h12
`define MODE_RESERVED 5'h13
`define MODE_IMMEDIATE 5'h14
`define MODE_EXTERNAL 5'h16
`define MODE_STACK_TOP 5'h17
// General register file shape and link-table entry scaling
`define GEN_REG_COUNT 8
`define GEN_REG_SEL_W 3
`define LINK_ENTRY_SHIFT 2
// Stack select bit position in the status word
`define PSW_STACK_SEL_BIT 9
// Decoded operation kinds
`define KIND_W 3
`define KIND_NONE 3'h0
`define KIND_DIRECT 3'h1
`define KIND_INDIRECT 3'h2
`define KIND_IMMEDIATE 3'h3
`define KIND_STACK_TOP 3'h4
`define KIND_ILLEGAL 3'h5
`endif

// [hw/stack_pointer_select.v]
`timescale 1ns/1ns
`include "addr_mode_regs.vh"
module stack_pointer_select #(
  parameter W = 32
) (
  input wire [W-1:0] processor_status_word,
  input wire [W-1:0] first_stack_pointer,
  input wire [W-1:0] second_stack_pointer,
  output wire [W-1:0] current_sp
);
  assign current_sp = processor_status_word[`PSW_STACK_SEL_BIT] ? second_stack_pointer :
                      first_stack_pointer;
endmodule // stack_pointer_select

// [hw/operand_address_mode_decoder.v]
// What this block does
// - Codes 01000..01111: address is displacement plus general register 0..7.
// - Memory-relative: read pointer at disp1 plus base, add disp2.
// - Stack references use the pointer chosen by the status word bit.
// - Immediate: no address; operand comes from the instruction queue.
// - External: pointer from link-table entry disp1, plus disp2.
// - Code 10111 addresses top of current stack with push or pop.
`timescale 1ns/1ns
`include "addr_mode_regs.vh"
module operand_address_mode_decoder #(
  parameter W = 32,
  parameter SIZE_W = 3
) (
  input wire clk,
  input wire reset,
  input wire start,
  input wire [`MODE_W-1:0] mode,
  input wire [W-1:0] disp1,
  input wire [W-1:0] disp2,
  input wire [W*`GEN_REG_COUNT-1:0] gen_regs,
  input wire [W-1:0] frame_base_pointer,
  input wire [W-1:0] static_base_pointer,
  input wire [W-1:0] link_table_base,
  input wire [W-1:0] processor_status_word,
  input wire [W-1:0] first_stack_pointer,
  input wire [W-1:0] second_stack_pointer,
  input wire is_write,
  input wire [SIZE_W-1:0] op_bytes,
  input wire [W-1:0] queue_data,
  input wire ptr_valid,
  input wire [W-1:0] ptr_data,
  output reg ptr_req,
  output reg [W-1:0] ptr_addr,
  output reg done,
  output reg [W-1:0] eff_addr,
  output reg operand_is_imm,
  output reg [W-1:0] imm_value,
  output reg illegal_mode,
  output reg sp_update,
  output reg sp_update_sel,
  output reg [W-1:0] sp_new_value,
  output reg busy
);
  localparam ST_IDLE = 1'b0;
  localparam ST_WAIT_PTR = 1'b1;
  localparam SEL_W = `GEN_REG_SEL_W;
  localparam CHAIN_W = W * (`GEN_REG_COUNT + 1);

  wire [W-1:0] current_sp;
  wire [CHAIN_W-1:0] reg_chain;
  wire [W-1:0] reg_sel;
  wire is_regrel;
  wire is_frame_mrel;
  wire is_stack_mrel;
  wire is_static_mrel;
  wire is_mem_rel;
  wire is_external;
  wire is_immediate;
  wire is_stack_top;
  wire is_reserved;
  wire needs_ptr;
  wire accept;
  wire stack_sel;
  wire [W-1:0] size_ext;
  wire [W-1:0] push_addr;
  wire [W-1:0] pop_next;
  wire [W-1:0] link_offset;
  reg state_r;
  reg state_nxt;
  reg [W-1:0] disp2_r;
  reg [W-1:0] base;
  reg [`KIND_W-1:0] kind;
  genvar g;

  ////////////////////////////////////////////////////////////////////////
  // Pointer choice lives in one place so the push/pop path and the
  // memory-relative path can never disagree about which stack is live
  stack_pointer_select #(.W(W)) u_sp_sel (
    .processor_status_word(processor_status_word),
    .first_stack_pointer(first_stack_pointer),
    .second_stack_pointer(second_stack_pointer),
    .current_sp(current_sp)
  );

  assign stack_sel = processor_status_word[`PSW_STACK_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Register pick as a masked OR chain: no priority logic is needed since
  // exactly one index matches a field of SEL_W bits
  assign reg_chain[W-1:0] = {W{1'b0}};
  generate
    for (g = 0; g < `GEN_REG_COUNT; g = g + 1) begin : gen_reg_pick
      wire hit;
      assign hit = {{(32-SEL_W){1'b0}}, mode[SEL_W-1:0]} == g;
      assign reg_chain[(g+1)*W +: W] = reg_chain[g*W +: W] | (gen_regs[g*W +: W] & {W{hit}});
    end
  endgenerate
  assign reg_sel = reg_chain[`GEN_REG_COUNT*W +: W];

  ////////////////////////////////////////////////////////////////////////
  // Mode field decode
  assign is_regrel = mode[`MODE_W-1:`MODE_W-2] == `MODE_REGREL_HI;
  assign is_frame_mrel = mode == `MODE_FRAME_MREL;
  assign is_stack_mrel = mode == `MODE_STACK_MREL;
  assign is_static_mrel = mode == `MODE_STATIC_MREL;
  assign is_mem_rel = is_frame_mrel || is_stack_mrel || is_static_mrel;
  assign is_external = mode == `MODE_EXTERNAL;
  assign is_immediate = mode == `MODE_IMMEDIATE;
  assign is_stack_top = mode == `MODE_STACK_TOP;
  assign is_reserved = mode == `MODE_RESERVED;
  assign needs_ptr = is_mem_rel || is_external;
  // Requests are only taken while no pointer read is outstanding
  assign accept = start && state_r == ST_IDLE;

  always @* begin
    kind = `KIND_NONE;
    if (accept) begin
      if (is_regrel) begin
        kind = `KIND_DIRECT;
      end else if (needs_ptr) begin
        kind = `KIND_INDIRECT;
      end else if (is_immediate) begin
        kind = `KIND_IMMEDIATE;
      end else if (is_stack_top) begin
        kind = `KIND_STACK_TOP;
      end else if (is_reserved) begin
        // Held-back code is flagged, never guessed at
        kind = `KIND_ILLEGAL;
      end else begin
        // Register-direct, absolute and memory-space forms are not built here
        kind = `KIND_ILLEGAL;
      end
    end
  end

  always @* begin
    case (mode)
      `MODE_FRAME_MREL: base = frame_base_pointer;
      `MODE_STACK_MREL: base = current_sp;
      `MODE_STATIC_MREL: base = static_base_pointer;
      default: base = {W{1'b0}};
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Address arithmetic
  // Link-table entries are one word each, so the index is scaled by a shift
  assign link_offset = {disp1[W-1-`LINK_ENTRY_SHIFT:0], {`LINK_ENTRY_SHIFT{1'b0}}};
  assign size_ext = {{(W-SIZE_W){1'b0}}, op_bytes};
  assign push_addr = current_sp - size_ext;
  assign pop_next = current_sp + size_ext;

  ////////////////////////////////////////////////////////////////////////
  // Sequencer: only pointer modes leave idle
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (kind == `KIND_INDIRECT) begin
          state_nxt = ST_WAIT_PTR;
        end
      end
      ST_WAIT_PTR: begin
        if (ptr_valid) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (reset) begin
      state_r <= ST_IDLE;
      disp2_r <= {W{1'b0}};
      ptr_req <= 1'b0;
      ptr_addr <= {W{1'b0}};
      done <= 1'b0;
      eff_addr <= {W{1'b0}};
      operand_is_imm <= 1'b0;
      imm_value <= {W{1'b0}};
      illegal_mode <= 1'b0;
      sp_update <= 1'b0;
      sp_update_sel <= 1'b0;
      sp_new_value <= {W{1'b0}};
      busy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      busy <= state_nxt == ST_WAIT_PTR;
      done <= 1'b0;
      operand_is_imm <= 1'b0;
      illegal_mode <= 1'b0;
      sp_update <= 1'b0;
      if (state_r == ST_WAIT_PTR && ptr_valid) begin
        ptr_req <= 1'b0;
        eff_addr <= ptr_data + disp2_r;
        done <= 1'b1;
      end
      // Kind is none while waiting, so this never collides with the return above
      case (kind)
        `KIND_DIRECT: begin
          eff_addr <= disp1 + reg_sel;
          done <= 1'b1;
        end
        `KIND_INDIRECT: begin
          // Second displacement is kept: the queue may move on during the read
          ptr_req <= 1'b1;
          disp2_r <= disp2;
          if (is_external) begin
            ptr_addr <= link_table_base + link_offset;
          end else begin
            ptr_addr <= disp1 + base;
          end
        end
        `KIND_IMMEDIATE: begin
          imm_value <= queue_data;
          operand_is_imm <= 1'b1;
          done <= 1'b1;
        end
        `KIND_STACK_TOP: begin
          // Push predecrements; pop hands out the old top, then moves it up
          eff_addr <= is_write ? push_addr : current_sp;
          sp_new_value <= is_write ? push_addr : pop_next;
          sp_update_sel <= stack_sel;
          sp_update <= 1'b1;
          done <= 1'b1;
        end
        `KIND_ILLEGAL: begin
          illegal_mode <= 1'b1;
          done <= 1'b1;
        end
        default: begin
          // No request taken this cycle; data outputs hold, except eff_addr when a pointer read returns
        end
      endcase
    end
  end
endmodule // operand_address_mode_decoder

// [verif/decoder_assertions.sv]
`timescale 1ns/1ns
module decoder_checker (
  input wire clk,
  input wire reset,
  input wire start,
  input wire busy,
  input wire [4:0] mode,
  input wire [31:0] processor_status_word,
  input wire done,
  input wire ptr_req,
  input wire operand_is_imm,
  input wire illegal_mode,
  input wire ptr_valid,
  input wire sp_update,
  input wire sp_update_sel
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire go = start && !busy;
  a_reg_rel_done: assert property (go && mode[4:3] == 2'h1 |=> done && !ptr_req) else $error("reg relative");
  a_mem_rel_fetch: assert property (go && mode[4:2] == 3'h4 && mode != 5'h13 |=> ptr_req && !done) else $error("mrel");
  a_stack_sel: assert property (go && mode == 5'h17 |=> sp_update_sel == $past(processor_status_word[9])) else $error("sel");
  a_imm_flag: assert property (go && mode == 5'h14 |=> done && operand_is_imm && !ptr_req) else $error("imm");
  a_ext_fetch: assert property (go && mode == 5'h16 |=> ptr_req ##0 !done) else $error("ext");
  a_stack_top: assert property (go && mode == 5'h17 |=> sp_update && done) else $error("stack top");
  a_illegal_flag: assert property (go && (mode[4:3] == 2'h0 || mode[4:3] == 2'h3 || mode == 5'h13 || mode == 5'h15)
    |=> done && illegal_mode && !ptr_req) else $error("illegal");
  a_ptr_return: assert property (busy && ptr_valid |=> done && !ptr_req && !busy) else $error("ptr return");
  a_busy_hold: assert property (busy && !ptr_valid |=> busy && ptr_req && !done) else $error("busy hold");
endmodule // decoder_checker
bind operand_address_mode_decoder decoder_checker chk (.clk(clk), .reset(reset), .start(start), .busy(busy),
  .mode(mode), .processor_status_word(processor_status_word), .done(done), .ptr_req(ptr_req),
  .operand_is_imm(operand_is_imm), .illegal_mode(illegal_mode), .ptr_valid(ptr_valid),
  .sp_update(sp_update), .sp_update_sel(sp_update_sel));

// [verif/tb_top.sv]
`timescale 1ns/1ns
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; $display("BAD %s %h %h", nm, e, g); end end
module tb_top;
  reg clk, reset, start, is_write, ptr_valid;
  reg [4:0] mode;
  reg [2:0] op_bytes;
  reg [31:0] d1, d2, fbp, sbp, ltb, psw, sp_first, sp_second, qd, pd;
  reg [255:0] regs;
  wire ptr_req, done, imm, ill, spu, sps, busy;
  wire [31:0] pa, ea, iv, spn;
  int n_errors = 0, compares = 0;
  operand_address_mode_decoder dut (.clk(clk), .reset(reset), .start(start), .mode(mode), .disp1(d1), .disp2(d2),
    .gen_regs(regs), .frame_base_pointer(fbp), .static_base_pointer(sbp), .link_table_base(ltb),
    .processor_status_word(psw), .first_stack_pointer(sp_first), .second_stack_pointer(sp_second),
    .is_write(is_write),
    .op_bytes(op_bytes), .queue_data(qd), .ptr_valid(ptr_valid), .ptr_data(pd), .ptr_req(ptr_req), .ptr_addr(pa),
    .done(done), .eff_addr(ea), .operand_is_imm(imm), .imm_value(iv), .illegal_mode(ill), .sp_update(spu),
    .sp_update_sel(sps), .sp_new_value(spn), .busy(busy));
  ////////////////////////////////////////////////////////////////
  task issue(input [4:0] m);
    @(posedge clk) #1 start = 1;
    mode = m;
    @(posedge clk) #1 start = 0;
  endtask
  task t_regrel;
    for (int n = 0; n < 8; n++) begin
      issue(5'h08 + n[4:0]);
      `CHK("regrel", {2'h2, d1 + regs[n*32+:32]}, {done, ptr_req, ea})
    end
  endtask
  task t_ptr(input [4:0] m, input [31:0] adr);
    issue(m);
    `CHK("ptr_addr", {2'h3, adr}, {ptr_req, busy, pa})
    // A second request while the pointer is out must be refused
    @(posedge clk) #1 start = 1;
    mode = 5'h08;
    @(posedge clk) #1 start = 0;
    ptr_valid = 1;
    `CHK("refused", 3'h3, {done, ptr_req, busy})
    @(posedge clk) #1 ptr_valid = 0;
    `CHK("ind_ea", {3'h4, pd + d2}, {done, ptr_req, busy, ea})
  endtask
  task t_imm;
    issue(5'h14);
    `CHK("imm", {3'h6, qd}, {done, imm, ptr_req, iv})
  endtask
  task t_stack_top(input w, input [2:0] sz);
    reg [31:0] sp;
    sp = psw[9] ? sp_second : sp_first;
    is_write = w;
    op_bytes = sz;
    issue(5'h17);
    `CHK("stack_top", {2'h3, psw[9], w ? sp - sz : sp + sz}, {done, spu, sps, spn})
    `CHK("stack_top_ea", w ? sp - sz : sp, ea)
  endtask
  task t_illegal(input [4:0] m);
    issue(m);
    `CHK("illegal", 5'h18, {done, ill, ptr_req, imm, spu})
  endtask
  task report_and_stop;
    $display("n_errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // Whole run needs well under 100 cycles
  initial begin
    #5000 n_errors++;
    report_and_stop;
  end
  initial begin
    reset = 1;
    start = 0;
    is_write = 0;
    ptr_valid = 0;
    mode = 5'h00;
    op_bytes = 3'h4;
    {d1, d2, fbp, sbp, ltb} = {32'h10, 32'h24, 32'h1000, 32'h2000, 32'h3000};
    {psw, sp_first, sp_second, qd, pd} = {32'h200, 32'h4000, 32'h5000, 32'hcafe0001, 32'h8000};
    for (int n = 0; n < 8; n++) regs[n*32+:32] = 32'h100 * (n + 1);
    repeat (5) @(posedge clk);
    #1 reset = 0;
    `CHK("reset_idle", 7'h00, {done, ptr_req, busy, imm, ill, spu, sps})
    t_regrel;
    t_ptr(5'h10, d1 + fbp);
    t_ptr(5'h11, d1 + sp_second);
    t_ptr(5'h12, d1 + sbp);
    t_ptr(5'h16, ltb + 4 * d1);
    t_imm;
    t_stack_top(0, 3'h4);
    t_stack_top(1, 3'h4);
    t_stack_top(1, 3'h2);
    psw = 0;
    t_stack_top(0, 3'h4);
    t_illegal(5'h13);
    t_illegal(5'h15);
    t_illegal(5'h00);
    t_illegal(5'h1f);
    report_and_stop;
  end
endmodule // tb_top
